// ### hdl/cih_regs.vh
// Register map, field positions, reset values and clock ratio codes of the card interface.
`ifndef CIH_REGS_VH
`define CIH_REGS_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CIH_OFF_CTRL 12'h000
`define CIH_OFF_STATUS 12'h004
`define CIH_OFF_IRQ_STATUS 12'h008
`define CIH_OFF_IRQ_MASK 12'h00c
// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CIH_CTRL_RELAY_EN 0
`define CIH_CTRL_DIV00_HALF 1
`define CIH_CTRL_RESET 2'h1
`define CIH_ST_SESSION 0
`define CIH_ST_PRESENT 1
`define CIH_ST_FAULT 2
`define CIH_ST_SYNC 3
`define CIH_ST_PDOWN 4
`define CIH_ST_VOLT5 5
`define CIH_ST_DIV_A 6
`define CIH_ST_DIV_B 7
`define CIH_IRQ_W 4
`define CIH_IRQ_INSERT 0
`define CIH_IRQ_REMOVE 1
`define CIH_IRQ_FAULT 2
`define CIH_IRQ_START 3
`define CIH_IRQ_RESET 4'h0
`define CIH_DATA_ZERO 32'h00000000
// ----------------------------------------------------------------------
// Card clock ratio codes
// ----------------------------------------------------------------------
`define CIH_RATIO_1 2'h0
`define CIH_RATIO_2 2'h1
`define CIH_RATIO_4 2'h2
`define CIH_RATIO_8 2'h3
// Oscillator rising edges per card clock half period for each divided ratio.
`define CIH_HALF_2 3'h1
`define CIH_HALF_4 3'h2
`define CIH_HALF_8 3'h4
`endif

// ### hdl/cih_clk_div.v
// Card clock divider driven by rising edges of the sampled oscillator input.
`timescale 1ns/1ps
`include "cih_regs.vh"
module cih_clk_div #(
  parameter CNT_W = 3
) (
  input wire clk_sys,
  input wire rst,
  input wire osc_input,
  input wire [1:0] ratio_code,
  output reg card_clk_div
);
  reg osc_q;
  reg [CNT_W-1:0] edge_cnt;
  reg [CNT_W-1:0] half_edges;
  wire osc_rise;

  assign osc_rise = osc_input & ~osc_q;

  // Toggle counts in oscillator edges per half period; edges are evenly spaced.
  always @* begin
    case (ratio_code)
      `CIH_RATIO_2: half_edges = `CIH_HALF_2;
      `CIH_RATIO_4: half_edges = `CIH_HALF_4;
      `CIH_RATIO_8: half_edges = `CIH_HALF_8;
      default: half_edges = `CIH_HALF_2;
    endcase
  end

  // Toggling on whole edge counts keeps each half equal, so duty stays at 50%.
  always @(posedge clk_sys) begin
    if (rst) begin
      osc_q <= 1'b0;
      edge_cnt <= 3'h0;
      card_clk_div <= 1'b0;
    end else begin
      osc_q <= osc_input;
      if (ratio_code == `CIH_RATIO_1) begin
        card_clk_div <= osc_input;
        edge_cnt <= 3'h0;
      end else if (osc_rise) begin
        if (edge_cnt == half_edges - 3'h1) begin
          card_clk_div <= ~card_clk_div;
          edge_cnt <= 3'h0;
        end else begin
          edge_cnt <= edge_cnt + 3'h1;
        end
      end
    end
  end
endmodule // cih_clk_div

// ### hdl/cih_line_relay.v
// Bidirectional open-drain relay between one host line and one card contact.
`timescale 1ns/1ps
module cih_line_relay (
  input wire clk_sys,
  input wire rst,
  input wire enable,
  input wire host_in,
  output wire host_out,
  output wire host_oe,
  input wire card_in,
  output wire card_out,
  output wire card_oe
);
  localparam ST_IDLE = 3'h1;
  localparam ST_H2C = 3'h2;
  localparam ST_C2H = 3'h4;
  reg [2:0] state;
  reg [2:0] next_state;

  // Whichever side pulls low first owns the line until it lets go.
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!host_in) next_state = ST_H2C;
        else if (!card_in) next_state = ST_C2H;
      end
      ST_H2C: if (host_in) next_state = ST_IDLE;
      ST_C2H: if (card_in) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst || !enable) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Only low levels are driven; the high level comes from the pull-up.
  assign host_out = 1'b0;
  assign card_out = 1'b0;
  assign host_oe = enable & (state == ST_C2H);
  assign card_oe = enable & (state == ST_H2C);
endmodule // cih_line_relay

// ### hdl/cih_top.v
// Host control logic of a single smart card interface with an APB register slave.
`timescale 1ns/1ps
`include "cih_regs.vh"
// Summary of operation
// - Select high: all host pins work normally.
// - Select low: host control inputs are held.
// - Select low: data lines float, no relaying.
// - Select low: status output released.
// - Sync select low: sequencer drives card clock/reset.
// - Sync select high: card clock copies strobe.
// - Sync select high: card reset follows host reset.
// - Aux lines relayed both ways, pulled up.
// - Clock output buffers oscillator input continuously.
// - Low activation request powers and activates card.
// - Power-down ignored while activation is requested.
// - Status: presence before activation, fault after.
// - Divided card clock duty between 45 and 55%.
module cih_top #(
  parameter ADDR_W = 12
) (
  input wire clk_sys,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output wire irq,
  // Host control pins
  input wire device_select,
  input wire activation_request_n,
  input wire host_card_reset_in,
  input wire power_down_request,
  input wire card_voltage_select,
  input wire clock_divide_sel_a,
  input wire clock_divide_sel_b,
  input wire sync_mode_select,
  input wire sync_strobe,
  input wire osc_input,
  output reg buffered_osc_out,
  output wire status_n_out,
  output reg status_n_oe,
  // Host data lines, open drain
  input wire host_card_io_in,
  output wire host_card_io_out,
  output wire host_card_io_oe,
  input wire host_aux_line_1_in,
  output wire host_aux_line_1_out,
  output wire host_aux_line_1_oe,
  input wire host_aux_line_2_in,
  output wire host_aux_line_2_out,
  output wire host_aux_line_2_oe,
  // Card contacts
  input wire card_io_in,
  output wire card_io_out,
  output wire card_io_oe,
  input wire card_aux_1_in,
  output wire card_aux_1_out,
  output wire card_aux_1_oe,
  input wire card_aux_2_in,
  output wire card_aux_2_out,
  output wire card_aux_2_oe,
  output reg card_clk,
  output reg card_rst,
  // Sequencer and protection side
  input wire card_present,
  input wire card_fault,
  output reg card_supply_enable,
  output reg card_voltage_5v,
  output reg power_down_active
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg act_req_n_l;
  reg rst_in_l;
  reg power_down_request_l;
  reg volt_l;
  reg div_a_l;
  reg div_b_l;
  reg sync_l;
  reg session_on;
  reg fault_lat;
  reg rst_enable;
  reg strobe_q;
  reg present_q;
  reg fault_q;
  reg session_q;
  reg [1:0] ctrl;
  reg [`CIH_IRQ_W-1:0] irq_status;
  reg [`CIH_IRQ_W-1:0] irq_mask;
  reg [`CIH_IRQ_W-1:0] next_irq_status;
  reg [`CIH_IRQ_W-1:0] irq_events;
  reg [1:0] ratio_code;
  reg [31:0] next_rdata;
  reg next_slverr;
  wire session_req;
  wire fault_cond;
  wire status_low;
  wire div_clk;
  wire relay_en;
  wire apb_setup;
  wire apb_write;
  wire apb_read;
  wire [2:0] host_in_bus;
  wire [2:0] card_in_bus;
  wire [2:0] host_out_bus;
  wire [2:0] host_oe_bus;
  wire [2:0] card_out_bus;
  wire [2:0] card_oe_bus;
  wire [7:0] status_word;

  // Address match, used by both the read and the write decode.
  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr == offset[ADDR_W-1:0]);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Host control latches
  // ----------------------------------------------------------------------
  // Transparent while selected, frozen while deselected so several devices
  // can share one control bus.
  always @(posedge clk_sys) begin
    if (rst) begin
      act_req_n_l <= 1'b1;
      rst_in_l <= 1'b0;
      power_down_request_l <= 1'b0;
      volt_l <= 1'b1;
      div_a_l <= 1'b0;
      div_b_l <= 1'b0;
      sync_l <= 1'b0;
    end else if (device_select) begin
      act_req_n_l <= activation_request_n;
      rst_in_l <= host_card_reset_in;
      power_down_request_l <= power_down_request;
      volt_l <= card_voltage_select;
      div_a_l <= clock_divide_sel_a;
      div_b_l <= clock_divide_sel_b;
      sync_l <= sync_mode_select;
    end
  end

  // ----------------------------------------------------------------------
  // Session control
  // ----------------------------------------------------------------------
  assign session_req = ~act_req_n_l;
  assign fault_cond = card_fault | ~card_present;

  // A fault ends the session and stays latched until the host withdraws its
  // request, so a faulty card is never reactivated without host action.
  always @(posedge clk_sys) begin
    if (rst) begin
      session_on <= 1'b0;
      fault_lat <= 1'b0;
      rst_enable <= 1'b0;
      card_supply_enable <= 1'b0;
      card_voltage_5v <= 1'b1;
      power_down_active <= 1'b0;
    end else begin
      if (!session_req) begin
        fault_lat <= 1'b0;
      end else if (session_on && fault_cond) begin
        fault_lat <= 1'b1;
      end
      if (!session_req || fault_lat || fault_cond) begin
        session_on <= 1'b0;
      end else if (card_present) begin
        session_on <= 1'b1;
      end
      rst_enable <= session_on;
      card_supply_enable <= session_on;
      card_voltage_5v <= volt_l;
      power_down_active <= power_down_request_l & act_req_n_l;
    end
  end

  // ----------------------------------------------------------------------
  // Card clock and reset
  // ----------------------------------------------------------------------
  // The all-zero selection is ambiguous; a control bit picks /8 or /2.
  always @* begin
    case ({clock_divide_sel_a_q(div_a_l), div_b_l})
      2'b01: ratio_code = `CIH_RATIO_4;
      2'b11: ratio_code = `CIH_RATIO_2;
      2'b10: ratio_code = `CIH_RATIO_1;
      default: ratio_code = ctrl[`CIH_CTRL_DIV00_HALF] ? `CIH_RATIO_2 : `CIH_RATIO_8;
    endcase
  end

  // Identity helper keeps the case selector readable.
  function clock_divide_sel_a_q;
    input v;
    begin
      clock_divide_sel_a_q = v;
    end
  endfunction

  cih_clk_div #(
    .CNT_W(3)
  ) u_clk_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .osc_input(osc_input),
    .ratio_code(ratio_code),
    .card_clk_div(div_clk)
  );

  // Async mode delays reset release by one sequencer step; sync mode passes
  // the host reset straight through. The strobe is unused in async mode.
  always @(posedge clk_sys) begin
    if (rst) begin
      strobe_q <= 1'b0;
      card_clk <= 1'b0;
      card_rst <= 1'b0;
      buffered_osc_out <= 1'b0;
    end else begin
      strobe_q <= sync_strobe;
      buffered_osc_out <= osc_input;
      if (sync_l) begin
        card_clk <= session_on & strobe_q;
        card_rst <= session_on & rst_in_l;
      end else begin
        card_clk <= session_on & div_clk;
        card_rst <= rst_enable & rst_in_l;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status output
  // ----------------------------------------------------------------------
  // Open drain: only the low level is driven, and released one clock after deselection.
  assign status_low = session_req ? fault_lat : ~card_present;
  assign status_n_out = 1'b0;

  always @(posedge clk_sys) begin
    if (rst) begin
      status_n_oe <= 1'b0;
    end else begin
      status_n_oe <= device_select & status_low;
    end
  end

  // ----------------------------------------------------------------------
  // Data line relays
  // ----------------------------------------------------------------------
  assign relay_en = device_select & ctrl[`CIH_CTRL_RELAY_EN];
  assign host_in_bus = {host_aux_line_2_in, host_aux_line_1_in, host_card_io_in};
  assign card_in_bus = {card_aux_2_in, card_aux_1_in, card_io_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_relay
      cih_line_relay u_relay (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(relay_en),
        .host_in(host_in_bus[gi]),
        .host_out(host_out_bus[gi]),
        .host_oe(host_oe_bus[gi]),
        .card_in(card_in_bus[gi]),
        .card_out(card_out_bus[gi]),
        .card_oe(card_oe_bus[gi])
      );
    end
  endgenerate

  assign host_card_io_out = host_out_bus[0];
  assign host_card_io_oe = host_oe_bus[0];
  assign host_aux_line_1_out = host_out_bus[1];
  assign host_aux_line_1_oe = host_oe_bus[1];
  assign host_aux_line_2_out = host_out_bus[2];
  assign host_aux_line_2_oe = host_oe_bus[2];
  assign card_io_out = card_out_bus[0];
  assign card_io_oe = card_oe_bus[0];
  assign card_aux_1_out = card_out_bus[1];
  assign card_aux_1_oe = card_oe_bus[1];
  assign card_aux_2_out = card_out_bus[2];
  assign card_aux_2_oe = card_oe_bus[2];

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      present_q <= 1'b0;
      fault_q <= 1'b0;
      session_q <= 1'b0;
    end else begin
      present_q <= card_present;
      fault_q <= fault_lat;
      session_q <= session_on;
    end
  end

  always @* begin
    irq_events = `CIH_IRQ_RESET;
    irq_events[`CIH_IRQ_INSERT] = card_present & ~present_q;
    irq_events[`CIH_IRQ_REMOVE] = ~card_present & present_q;
    irq_events[`CIH_IRQ_FAULT] = fault_lat & ~fault_q;
    irq_events[`CIH_IRQ_START] = session_on & ~session_q;
  end

  // A read clears only the bits captured for it, so a later event is never lost.
  always @* begin
    next_irq_status = irq_status;
    if (apb_read && addr_hit(paddr, `CIH_OFF_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~prdata[`CIH_IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Zero wait states: read data is captured in the setup cycle so that it
  // comes from a flip-flop yet is valid throughout the access cycle.
  assign pready = 1'b1;
  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;
  assign apb_read = psel & penable & ~pwrite;
  assign status_word = {div_b_l, div_a_l, volt_l, power_down_active, sync_l,
                        fault_lat, card_present, session_on};

  always @* begin
    next_rdata = `CIH_DATA_ZERO;
    next_slverr = 1'b0;
    if (addr_hit(paddr, `CIH_OFF_CTRL)) begin
      next_rdata[1:0] = ctrl;
    end else if (addr_hit(paddr, `CIH_OFF_STATUS)) begin
      next_rdata[7:0] = status_word;
    end else if (addr_hit(paddr, `CIH_OFF_IRQ_STATUS)) begin
      next_rdata[`CIH_IRQ_W-1:0] = irq_status;
    end else if (addr_hit(paddr, `CIH_OFF_IRQ_MASK)) begin
      next_rdata[`CIH_IRQ_W-1:0] = irq_mask;
    end else begin
      next_slverr = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      prdata <= `CIH_DATA_ZERO;
      pslverr <= 1'b0;
      ctrl <= `CIH_CTRL_RESET;
      irq_mask <= `CIH_IRQ_RESET;
      irq_status <= `CIH_IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
      if (apb_setup) begin
        prdata <= pwrite ? `CIH_DATA_ZERO : next_rdata;
        pslverr <= next_slverr;
      end
      if (apb_write && addr_hit(paddr, `CIH_OFF_CTRL)) begin
        ctrl <= pwdata[1:0];
      end
      if (apb_write && addr_hit(paddr, `CIH_OFF_IRQ_MASK)) begin
        irq_mask <= pwdata[`CIH_IRQ_W-1:0];
      end
    end
  end
endmodule // cih_top

// ### verification/cih_top_properties.sv
// Concurrent checks on the pins of the card interface host control block.
`timescale 1ns/1ps
module cih_top_properties (
  input wire clk_sys,
  input wire rst,
  input wire device_select,
  input wire activation_request_n,
  input wire host_card_reset_in,
  input wire sync_mode_select,
  input wire sync_strobe,
  input wire osc_input,
  input wire buffered_osc_out,
  input wire status_n_oe,
  input wire host_card_io_oe,
  input wire host_aux_line_1_oe,
  input wire host_aux_line_2_oe,
  input wire card_present,
  input wire card_fault,
  input wire card_clk,
  input wire card_rst,
  input wire card_supply_enable,
  input wire power_down_active
);
  // ------------------------------------------------------------
  // Timing context and multi-step sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Runs of four cycles let the input latches and the session settle first.
  sequence s_sync_run;
    (device_select && sync_mode_select && card_supply_enable)[*4];
  endsequence
  sequence s_req_run;
    (device_select && !activation_request_n && card_present && !card_fault)[*4];
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_osc_copy;
    !$past(rst) |-> buffered_osc_out == $past(osc_input);
  endproperty
  property p_sel_release;
    !device_select |-> !(host_card_io_oe || host_aux_line_1_oe || host_aux_line_2_oe);
  endproperty
  property p_status_release;
    !device_select [*2] |-> !status_n_oe;
  endproperty
  property p_pd_block;
    (device_select && !activation_request_n)[*3] |-> !power_down_active;
  endproperty
  property p_sync_clk;
    s_sync_run |-> card_clk == $past(sync_strobe, 2);
  endproperty
  property p_sync_rst;
    (s_sync_run and $stable(host_card_reset_in)[*4]) |-> card_rst == host_card_reset_in;
  endproperty
  property p_idle_contacts;
    !card_supply_enable [*3] |-> !card_clk && !card_rst;
  endproperty
  property p_session;
    s_req_run |-> card_supply_enable;
  endproperty
  // Each check ties an output to the condition that must cause it.
  a_osc_copy: assert property (p_osc_copy)
    else $error("clock output is not the delayed oscillator");
  a_sel_release: assert property (p_sel_release)
    else $error("host line driven while deselected");
  a_status_release: assert property (p_status_release)
    else $error("status line driven while deselected");
  a_pd_block: assert property (p_pd_block)
    else $error("power down entered during a session");
  a_sync_clk: assert property (p_sync_clk)
    else $error("card clock does not follow the strobe");
  a_sync_rst: assert property (p_sync_rst)
    else $error("card reset does not follow host reset");
  a_idle_contacts: assert property (p_idle_contacts)
    else $error("card contacts active outside a session");
  a_session: assert property (p_session)
    else $error("session did not start on request");
endmodule // cih_top_properties

bind cih_top cih_top_properties u_cih_top_properties (.*);

// ### verification/cih_host_model.sv
// Host controller model: open-drain line levels on the host and card sides.
`timescale 1ns/1ps
module cih_host_model (
  input wire [2:0] host_pull_low,
  input wire [2:0] card_pull_low,
  input wire [2:0] dut_host_out,
  input wire [2:0] dut_host_oe,
  input wire [2:0] dut_card_out,
  input wire [2:0] dut_card_oe,
  input wire dut_status_out,
  input wire dut_status_oe,
  output wire [2:0] host_line,
  output wire [2:0] card_line,
  output wire status_line
);
  // Every line has a pull-up, so a released line reads high, never stale.
  // A driven line shows the level the device puts out, so a stuck output is seen.
  assign host_line = ~host_pull_low & (~dut_host_oe | dut_host_out);
  assign card_line = ~card_pull_low & (~dut_card_oe | dut_card_out);
  // The shared status line floats high unless the device pulls it low.
  assign status_line = ~dut_status_oe | dut_status_out;
endmodule // cih_host_model

// ### verification/tb_cih_top.sv
// Self-checking bench for the card interface host control block.
`timescale 1ns/1ps
`include "cih_regs.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 64) begin settle(1); k++; end \
  if (k >= 64) begin bad_count++; $display("CHECK FAILED wait exp 1 got 0"); \
  report_and_stop(); end end
module tb_cih_top;
  // ------------------------------------------------------------
  // Signals, design and host model
  // ------------------------------------------------------------
  logic clk_sys, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, prev;
  logic device_select = 1'b1, activation_request_n = 1'b1, host_card_reset_in = 1'b0;
  logic power_down_request = 1'b0, card_voltage_select = 1'b1, sync_mode_select = 1'b0;
  logic clock_divide_sel_a = 1'b0, clock_divide_sel_b = 1'b1, card_present = 1'b0;
  logic card_fault = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [2:0] host_pull_low = 3'h0, card_pull_low = 3'h0, osc_cnt = 3'h0;
  int bad_count = 0, total_checks = 0, k, rises, highs, expn;
  wire pready, pslverr, irq, buffered_osc_out, status_n_out, status_n_oe, status_line;
  wire card_clk, card_rst, card_supply_enable, card_voltage_5v, power_down_active;
  wire osc_input, sync_strobe;
  wire [31:0] prdata;
  wire [2:0] host_line, card_line;
  wire host_card_io_in, host_card_io_out, host_card_io_oe, host_aux_line_1_in;
  wire host_aux_line_1_out, host_aux_line_1_oe, host_aux_line_2_in, host_aux_line_2_out;
  wire host_aux_line_2_oe, card_io_in, card_io_out, card_io_oe, card_aux_1_in;
  wire card_aux_1_out, card_aux_1_oe, card_aux_2_in, card_aux_2_out, card_aux_2_oe;
  // Row: ratio in bits 6:3, half choice for 00 in bit 2, divide select b, a.
  logic [6:0] rows [5] = '{7'h22, 7'h13, 7'h09, 7'h40, 7'h14};
  assign {host_aux_line_2_in, host_aux_line_1_in, host_card_io_in} = host_line;
  assign {card_aux_2_in, card_aux_1_in, card_io_in} = card_line;
  // Oscillator at an eighth of the system clock keeps it well below half rate.
  assign osc_input = osc_cnt[2];
  assign sync_strobe = osc_cnt[1];
  cih_top u_cih_top (.*);
  cih_host_model u_cih_host_model (
    .host_pull_low(host_pull_low),
    .card_pull_low(card_pull_low),
    .dut_host_out({host_aux_line_2_out, host_aux_line_1_out, host_card_io_out}),
    .dut_host_oe({host_aux_line_2_oe, host_aux_line_1_oe, host_card_io_oe}),
    .dut_card_out({card_aux_2_out, card_aux_1_out, card_io_out}),
    .dut_card_oe({card_aux_2_oe, card_aux_1_oe, card_io_oe}),
    .dut_status_out(status_n_out),
    .dut_status_oe(status_n_oe),
    .host_line(host_line),
    .card_line(card_line),
    .status_line(status_line)
  );
  // Clock and free-running oscillator counter.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    osc_cnt <= osc_cnt + 3'h1;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      bad_count++;
      $display("CHECK FAILED pready exp 1 got 0");
      report_and_stop();
    end
  endtask
  // Pull one line low from one side, then release it, watching the other side.
  task automatic relay(input int i, input logic h);
    @(posedge clk_sys);
    if (h) host_pull_low[i] <= 1'b1;
    else card_pull_low[i] <= 1'b1;
    settle(3);
    `CHK("relay_low", 1'b0, h ? card_line[i] : host_line[i])
    @(posedge clk_sys);
    host_pull_low[i] <= 1'b0;
    card_pull_low[i] <= 1'b0;
    settle(3);
    `CHK("relay_idle", 1'b1, h ? card_line[i] : host_line[i])
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `CIH_OFF_CTRL, 32'h0);
    `CHK("ctrl_reset", {30'h0, `CIH_CTRL_RESET}, rd)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, `CIH_OFF_IRQ_MASK, 32'h1);
    @(posedge clk_sys);
    card_present <= 1'b1;
    `WAITC(irq === 1'b1)
    `CHK("status_present", 1'b1, status_line)
    apb(1'b0, `CIH_OFF_IRQ_STATUS, 32'h0);
    `CHK("irq_insert", 1'b1, rd[`CIH_IRQ_INSERT])
    settle(1);
    `CHK("irq_clear", 1'b0, irq)
    apb(1'b1, `CIH_OFF_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    card_present <= 1'b0;
    settle(4);
    `CHK("irq_masked", 1'b0, irq)
    `CHK("status_absent", 1'b0, status_line)
    apb(1'b0, `CIH_OFF_IRQ_STATUS, 32'h0);
    `CHK("irq_remove", 1'b1, rd[`CIH_IRQ_REMOVE])
    // Session request with power down asked for at the same time.
    @(posedge clk_sys);
    card_present <= 1'b1;
    activation_request_n <= 1'b0;
    power_down_request <= 1'b1;
    `WAITC(card_supply_enable === 1'b1)
    settle(4);
    `CHK("pd_ignored", 1'b0, power_down_active)
    @(posedge clk_sys);
    power_down_request <= 1'b0;
    for (int i = 0; i < 6; i++) relay(i % 3, i < 3);
    // Divider rows: count card clock edges and high time over 32 oscillator periods.
    foreach (rows[r]) begin
      apb(1'b1, `CIH_OFF_CTRL, {30'h0, rows[r][2], 1'b1});
      @(posedge clk_sys);
      clock_divide_sel_a <= rows[r][0];
      clock_divide_sel_b <= rows[r][1];
      settle(80);
      rises = 0;
      highs = 0;
      repeat (256) begin
        prev = card_clk;
        settle(1);
        rises += (card_clk === 1'b1 && prev === 1'b0);
        highs += (card_clk === 1'b1);
      end
      expn = 32 / rows[r][6:3];
      `CHK("div_rate", 1'b1, rises >= expn - 1 && rises <= expn + 1)
      `CHK("div_duty", 1'b1, highs * 100 >= 45 * 256 && highs * 100 <= 55 * 256)
    end
    // Async mode: once the sequencer enables it, card reset follows host reset.
    @(posedge clk_sys);
    host_card_reset_in <= 1'b1;
    settle(6);
    `CHK("async_rst_hi", 1'b1, card_rst)
    // Sync mode: card reset follows the host reset level.
    @(posedge clk_sys);
    sync_mode_select <= 1'b1;
    settle(6);
    `CHK("sync_rst_hi", 1'b1, card_rst)
    @(posedge clk_sys);
    host_card_reset_in <= 1'b0;
    settle(6);
    `CHK("sync_rst_lo", 1'b0, card_rst)
    // Deselect, then change inputs and raise a fault behind the frozen latches.
    @(posedge clk_sys);
    device_select <= 1'b0;
    @(posedge clk_sys);
    card_voltage_select <= 1'b0;
    card_fault <= 1'b1;
    host_pull_low[0] <= 1'b1;
    settle(4);
    `CHK("volt_held", 1'b1, card_voltage_5v)
    `CHK("status_float", 1'b1, status_line)
    `CHK("no_relay", 1'b1, card_line[0])
    @(posedge clk_sys);
    device_select <= 1'b1;
    host_pull_low[0] <= 1'b0;
    settle(4);
    `CHK("volt_new", 1'b0, card_voltage_5v)
    `CHK("fault_status", 1'b0, status_line)
    `CHK("deactivated", 1'b0, card_supply_enable)
    @(posedge clk_sys);
    activation_request_n <= 1'b1;
    card_fault <= 1'b0;
    power_down_request <= 1'b1;
    `WAITC(power_down_active === 1'b1)
    `CHK("pd_entered", 1'b1, power_down_active)
    // Reset in mid-run must drop the held outputs and the control register.
    @(posedge clk_sys);
    rst <= 1'b1;
    settle(2);
    `CHK("rst_pd", 1'b0, power_down_active)
    `CHK("rst_volt", 1'b1, card_voltage_5v)
    `CHK("rst_osc", 1'b0, buffered_osc_out)
    @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `CIH_OFF_CTRL, 32'h0);
    `CHK("rst_ctrl", {30'h0, `CIH_CTRL_RESET}, rd)
    report_and_stop();
  end
endmodule // tb_cih_top
